// ==== hdl/cces_map.vh ====
// Purpose: register offsets, field positions and reset values for the control channel error status bank
// Assumes: byte-wide register port, 8-bit offsets
// Notes: definitions only
`ifndef CCES_MAP_VH
`define CCES_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define CCES_OFS_ERR_CTL      8'h46
`define CCES_OFS_ERR_FLAGS    8'h47
`define CCES_OFS_LINK_CAP     8'h4A
`define CCES_OFS_PORT_SEL     8'h4C

// ****************************************
// field positions
// ****************************************
`define CCES_BIT_SEQ_ERR      5
`define CCES_BIT_CTRL_ERR     4
`define CCES_BIT_CTRL_TO      3
`define CCES_BIT_TGT_ERR      2
`define CCES_BIT_TGT_TO       1
`define CCES_BIT_RESP_ERR     0
`define CCES_BIT_ENH_EN       5
`define CCES_BIT_ENC_CRC_EN   4
`define CCES_BIT_ENC_CRC_DIS  7

// ****************************************
// reset values and masks
// ****************************************
`define CCES_RST_ERR_CTL      8'h20
`define CCES_RST_ERR_FLAGS    8'h00
`define CCES_RST_LINK_CAP     8'h00
`define CCES_RST_PORT_SEL     8'h00
`define CCES_MASK_ERR_CTL     8'hFF
`define CCES_MASK_LINK_CAP    8'h10

`endif

// ==== hdl/cces_sync.v ====
// Purpose: two flip-flop synchroniser for a bundle of pin-level inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage is read only by the second stage
module cces_sync
#(
	parameter WIDTH = 1
)
(
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge clk)
	begin
		if (rst)
		begin
			meta_reg <= {WIDTH{1'b0}};
			q        <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ==== hdl/cces_port_flags.v ====
// Purpose: one receive port's copy of the control channel error flags and capability bit
// Assumes: events are single-cycle pulses in the core clock domain
// Notes: a clearing read and a new event in the same cycle leave the flag set
`include "cces_map.vh"
module cces_port_flags
(
	input  wire       clk,
	input  wire       rst,
	input  wire       enh_en,
	input  wire       seq_err_mirror,
	input  wire       seq_err_ev,
	input  wire       ctrl_err_ev,
	input  wire       ctrl_to_ev,
	input  wire       tgt_err_ev,
	input  wire       tgt_to_ev,
	input  wire       resp_err_ev,
	input  wire       flags_rd,
	input  wire       cap_wr,
	input  wire [7:0] wdata,
	output wire [7:0] flags,
	output wire [7:0] cap
);
	reg [5:0] flag_reg;
	reg [5:0] flag_next;
	reg [7:0] cap_reg;
	reg [5:0] ev;
	reg [5:0] clr;

	// ****************************************
	// sticky flags
	// ****************************************
	always @*
	begin
		ev = 6'h00;
		ev[`CCES_BIT_SEQ_ERR]  = seq_err_ev;                     // RULE1
		ev[`CCES_BIT_CTRL_ERR] = enh_en & ctrl_err_ev;           // RULE4
		ev[`CCES_BIT_CTRL_TO]  = enh_en & ctrl_to_ev;            // RULE5
		ev[`CCES_BIT_TGT_ERR]  = enh_en & tgt_err_ev;            // RULE6
		ev[`CCES_BIT_TGT_TO]   = tgt_to_ev;                      // RULE7
		ev[`CCES_BIT_RESP_ERR] = enh_en & resp_err_ev;           // RULE8
		clr = flags_rd ? 6'h3F : 6'h00;
		// set wins over clear
		flag_next = (flag_reg & ~clr) | ev;                      // RULE14
		// with checking off the sequence flag just follows the port status bit
		if (!enh_en)
		begin
			flag_next[`CCES_BIT_SEQ_ERR] = seq_err_mirror;       // RULE2
		end
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			flag_reg <= 6'h00;
			cap_reg  <= `CCES_RST_LINK_CAP;
		end
		else
		begin
			flag_reg <= flag_next;                               // RULE3
			if (cap_wr)
			begin
				cap_reg <= wdata & `CCES_MASK_LINK_CAP;          // RULE11
			end
		end
	end

	assign flags = {2'b00, flag_reg};
	assign cap   = cap_reg;
endmodule

// ==== hdl/cces_top.v ====
// Purpose: per-port control channel error status and link capability registers
// Assumes: byte register port (address, write strobe, read strobe, data) from the serial control interface
// Notes: four port copies; read port and write enables come from the port select register
`include "cces_map.vh"

// Function
// RULE1: sequence error sets status bit five
// RULE2: checking off: bit five mirrors port status
// RULE3: checking on: reading status clears bit five
// RULE4: controller-side link error sets bit four
// RULE5: controller-side watchdog expiry sets bit three
// RULE6: target-side link error sets bit two
// RULE7: target-side watchdog expiry sets bit one
// RULE8: returned data mismatch sets bit zero
// RULE9: serializer echoes written or read data back
// RULE10: port select register routes reads and writes
// RULE11: capability bit four gates encoder CRC flag
// RULE12: CRC flag also needs encoder CRC enabled
// RULE13: enhanced checking enable, control bit five
// RULE14: event during clearing read keeps flag
module cces_top
#(
	parameter PORTS = 4
)
(
	input  wire             CORE_CLK,
	input  wire             RST,
	input  wire [7:0]       REG_ADDR,
	input  wire [7:0]       REG_WDATA,
	input  wire             REG_WR,
	input  wire             REG_RD,
	output reg  [7:0]       REG_RDATA,
	output reg              REG_RVALID,
	input  wire [PORTS-1:0] SEQ_ERR_EV,
	input  wire [PORTS-1:0] SEQ_ERR_STS,
	input  wire [PORTS-1:0] LINK_ERR_EV,
	input  wire [PORTS-1:0] CRC_ERR_EV,
	input  wire [PORTS-1:0] CTRL_WAIT,
	input  wire [PORTS-1:0] TGT_WAIT,
	input  wire [PORTS-1:0] WDOG_EXP_EV,
	input  wire [PORTS-1:0] RESP_MISMATCH_EV,
	input  wire             ENC_CRC_DISABLE,
	output reg  [PORTS-1:0] ENH_CHECK_EN,
	output reg  [PORTS-1:0] ENC_CRC_FLAG_EN
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	wire [PORTS-1:0] seq_sts_s;

	// only the level status needs crossing; events come from core-clock logic
	cces_sync #(.WIDTH(PORTS)) u_sync
	(
		.clk (CORE_CLK),
		.rst (RST),
		.d   (SEQ_ERR_STS),
		.q   (seq_sts_s)
	);

	// ****************************************
	// shared registers
	// ****************************************
	reg  [7:0] port_sel_reg;

	wire [1:0] rd_port = port_sel_reg[5:4];
	wire [3:0] wr_en   = port_sel_reg[3:0];
	// one-hot read port, so a clearing read only touches the selected copy
	wire [3:0] rd_dec  = 4'h1 << rd_port;

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	wire wr_sel   = REG_WR & hit(REG_ADDR, `CCES_OFS_PORT_SEL);
	wire wr_ctl   = REG_WR & hit(REG_ADDR, `CCES_OFS_ERR_CTL);
	wire wr_cap   = REG_WR & hit(REG_ADDR, `CCES_OFS_LINK_CAP);
	wire rd_flags = REG_RD & hit(REG_ADDR, `CCES_OFS_ERR_FLAGS);

	always @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			port_sel_reg <= `CCES_RST_PORT_SEL;
		end
		else if (wr_sel)
		begin
			// physical port number reads as zero locally
			port_sel_reg <= {2'b00, REG_WDATA[5:0]};             // RULE10
		end
	end

	// ****************************************
	// per-port copies
	// ****************************************
	wire [7:0]       flags_w [0:PORTS-1];
	wire [7:0]       cap_w   [0:PORTS-1];
	wire [7:0]       ctl_w   [0:PORTS-1];
	wire [PORTS-1:0] enh_w;
	wire [PORTS-1:0] crc_en_w;

	genvar p;
	generate
		for (p = 0; p < PORTS; p = p + 1)
		begin : g_port
			// each copy owns its control byte so every register has one driver
			reg  [7:0] ctl_reg;
			wire       enh = ctl_reg[`CCES_BIT_ENH_EN];

			always @(posedge CORE_CLK)
			begin
				if (RST)
				begin
					ctl_reg <= `CCES_RST_ERR_CTL;                   // RULE13
				end
				else if (wr_ctl & wr_en[p])
				begin
					ctl_reg <= REG_WDATA & `CCES_MASK_ERR_CTL;      // RULE10
				end
			end

			assign ctl_w[p]    = ctl_reg;
			assign enh_w[p]    = enh;
			assign crc_en_w[p] = cap_w[p][`CCES_BIT_ENC_CRC_EN] & ~ENC_CRC_DISABLE; // RULE11 RULE12

			cces_port_flags u_flags
			(
				.clk            (CORE_CLK),
				.rst            (RST),
				.enh_en         (enh),
				.seq_err_mirror (seq_sts_s[p]),
				.seq_err_ev     (SEQ_ERR_EV[p]),
				.ctrl_err_ev    (CTRL_WAIT[p] & (LINK_ERR_EV[p] | CRC_ERR_EV[p])), // RULE4
				.ctrl_to_ev     (CTRL_WAIT[p] & WDOG_EXP_EV[p]),                 // RULE5
				.tgt_err_ev     (TGT_WAIT[p] & (LINK_ERR_EV[p] | CRC_ERR_EV[p])),  // RULE6
				.tgt_to_ev      (TGT_WAIT[p] & WDOG_EXP_EV[p]),                  // RULE7
				.resp_err_ev    (RESP_MISMATCH_EV[p]),                            // RULE8
				.flags_rd       (rd_flags & rd_dec[p]),                           // RULE3
				.cap_wr         (wr_cap & wr_en[p]),
				.wdata          (REG_WDATA),
				.flags          (flags_w[p]),
				.cap            (cap_w[p])
			);
		end
	endgenerate

	always @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			ENH_CHECK_EN    <= {PORTS{1'b1}};                    // RULE13
			ENC_CRC_FLAG_EN <= {PORTS{1'b0}};
		end
		else
		begin
			ENH_CHECK_EN    <= enh_w;
			ENC_CRC_FLAG_EN <= crc_en_w;                         // RULE11 RULE12
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	reg [7:0] rdata_next;

	always @*
	begin
		case (REG_ADDR)
		`CCES_OFS_PORT_SEL:   rdata_next = port_sel_reg;
		`CCES_OFS_ERR_CTL:    rdata_next = ctl_w[rd_port];
		`CCES_OFS_ERR_FLAGS:  rdata_next = flags_w[rd_port];    // RULE10
		`CCES_OFS_LINK_CAP:   rdata_next = cap_w[rd_port];
		default:              rdata_next = 8'h00;
		endcase
	end

	always @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RVALID <= REG_RD;
			if (REG_RD)
			begin
				REG_RDATA <= rdata_next;
			end
		end
	end
endmodule

// ==== bench/cces_props.sv ====
// Purpose: port-level checks of the error status bank
// Assumes: single clock, synchronous reset
// Notes: bound into cces_top
module cces_props
#(
	parameter PORTS = 4
)
(
	input wire             CORE_CLK,
	input wire             RST,
	input wire [7:0]       REG_ADDR,
	input wire             REG_RD,
	input wire [7:0]       REG_RDATA,
	input wire             REG_RVALID,
	input wire [PORTS-1:0] SEQ_ERR_EV,
	input wire [PORTS-1:0] LINK_ERR_EV,
	input wire [PORTS-1:0] CRC_ERR_EV,
	input wire [PORTS-1:0] WDOG_EXP_EV,
	input wire [PORTS-1:0] RESP_MISMATCH_EV,
	input wire             ENC_CRC_DISABLE,
	input wire [PORTS-1:0] ENH_CHECK_EN,
	input wire [PORTS-1:0] ENC_CRC_FLAG_EN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	wire quiet = !(|{SEQ_ERR_EV, LINK_ERR_EV, CRC_ERR_EV, WDOG_EXP_EV, RESP_MISMATCH_EV});
	wire mapped = REG_ADDR inside {8'h46, 8'h47, 8'h4A, 8'h4C};
	sequence s_rd(a);
		REG_RD && REG_ADDR == a;
	endsequence
	// two back-to-back status reads with no event in either read cycle
	sequence s_clr;
		REG_RD && REG_ADDR == 8'h47 && quiet && &ENH_CHECK_EN ##1 REG_RD && REG_ADDR == 8'h47 && quiet;
	endsequence
	AST_RV: assert property (REG_RD |=> REG_RVALID)
		else $error("read without valid");
	AST_NORV: assert property (!REG_RD |=> !REG_RVALID)
		else $error("valid without read");
	AST_ENH_RST: assert property ($fell(RST) |-> ENH_CHECK_EN == {PORTS{1'b1}})
		else $error("enable not set after reset");
	AST_UNMAP: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	AST_RESV: assert property (s_rd(8'h47) |=> REG_RDATA[7:6] == 2'h0)
		else $error("status top bits set");
	AST_CAP: assert property (s_rd(8'h4A) |=> (REG_RDATA & 8'hEF) == 8'h00)
		else $error("capability reserved bits set");
	AST_CRC: assert property (ENC_CRC_DISABLE |=> ENC_CRC_FLAG_EN == '0)
		else $error("crc flag on while disabled");
	AST_CLR: assert property (s_clr |=> REG_RDATA[5:0] == 6'h00)
		else $error("flags survive read");
endmodule
bind cces_top cces_props #(.PORTS(PORTS)) chk (.*);

// ==== bench/cces_partner.sv ====
// Purpose: far-side serializer events for four ports
// Assumes: driven at falling edge
// Notes: wait levels frame each event by one cycle
module cces_partner
(
	input  wire        clk,
	output logic [3:0] seq,
	output logic [3:0] lnk,
	output logic [3:0] crc,
	output logic [3:0] wdg,
	output logic [3:0] rsp,
	output logic [3:0] cw,
	output logic [3:0] tw
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {seq, lnk, crc, wdg, rsp, cw, tw} = '0;
	// k is the flag bit the event should land in; c picks a crc error instead of a link error
	task pulse(input int k, input int p, input bit c);
		@(negedge clk);
		cw[p] = k == 4 || k == 3;
		tw[p] = k == 2 || k == 1;
		@(negedge clk);
		seq[p] = k == 5;
		lnk[p] = (k == 4 || k == 2) && !c;
		crc[p] = (k == 4 || k == 2) && c;
		wdg[p] = k == 3 || k == 1;
		rsp[p] = k == 0;
		@(negedge clk);
		{seq[p], lnk[p], crc[p], wdg[p], rsp[p]} = '0;
		@(negedge clk);
		{cw[p], tw[p]} = '0;
	endtask
endmodule

// ==== bench/ctl_chan_error_status_tb.sv ====
// Purpose: self-checking bench for the error status bank
// Assumes: one strobe per access, driven at falling edge
// Notes: events come from the partner model
module ctl_chan_error_status_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 0;
	logic       rst = 1;
	logic [7:0] addr = 0;
	logic [7:0] wdata = 0;
	logic       wr = 0;
	logic       rd = 0;
	logic [3:0] sts = 0;
	logic       crc_dis = 0;
	logic [7:0] v;
	logic [3:0] m;
	wire  [7:0] rdata;
	wire        rvalid;
	wire  [3:0] seq, lnk, crc, wdg, rsp, cw, tw, enh, cap_en;
	int         fail_count = 0;
	int         checked = 0;
	int         cyc = 0;
	int         p;
	always #12.5 clk = ~clk;
	cces_top uut (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .SEQ_ERR_EV(seq), .SEQ_ERR_STS(sts), .LINK_ERR_EV(lnk),
		.CRC_ERR_EV(crc), .CTRL_WAIT(cw), .TGT_WAIT(tw), .WDOG_EXP_EV(wdg), .RESP_MISMATCH_EV(rsp),
		.ENC_CRC_DISABLE(crc_dis), .ENH_CHECK_EN(enh), .ENC_CRC_FLAG_EN(cap_en));
	cces_partner fs (.clk(clk), .seq(seq), .lnk(lnk), .crc(crc), .wdg(wdg), .rsp(rsp), .cw(cw), .tw(tw));
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			final_report;
		end
	end
	function logic [7:0] exp_flag(int k, int en);
		return (en || k == 1) ? 8'(1 << k) : 8'h00;
	endfunction
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// the strobe is left up so reads can run back to back
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		{rd, wr, addr, wdata} = {!w, w, a, d};
		@(negedge clk);
	endtask
	task rreg(input logic [7:0] a, input logic [7:0] e, input string n);
		acc(0, a, 8'h00);
		chk(n, e, rdata);
		chk("rvalid", 8'h01, {7'h0, rvalid});
	endtask
	task idle;
		{rd, wr} = 2'b00;
		@(negedge clk);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		v = $urandom(32'h9469);
		repeat (6) @(negedge clk);
		rst = 0;
		chk("enh", 8'h0F, {4'h0, enh});
		for (p = 0; p < 4; p++)
		begin
			acc(1, 8'h4C, 8'(p << 4));
			rreg(8'h4C, 8'(p << 4), "sel");
			rreg(8'h46, 8'h20, "ctl");
			rreg(8'h47, 8'h00, "flags");
			rreg(8'h4A, 8'h00, "cap");
		end
		rreg(8'h48, 8'h00, "unmapped");
		$display("reset test done");
		for (int en = 1; en >= 0; en--)
		begin
			acc(1, 8'h4C, 8'h0F);
			acc(1, 8'h46, 8'(en << 5));
			idle;
			chk("enh", en ? 8'h0F : 8'h00, {4'h0, enh});
			for (int i = 0; i < 24; i++)
			begin
				p = $urandom % 4;
				acc(1, 8'h4C, 8'(p << 4));
				idle;
				fs.pulse(i % 6, p, 1'($urandom));
				rreg(8'h47, exp_flag(i % 6, en), "flag");
				rreg(8'h47, 8'h00, "cleared");
			end
		end
		$display("event test done");
		sts = 4'hF;
		repeat (4) idle;
		for (p = 0; p < 4; p++)
		begin
			acc(1, 8'h4C, 8'(p << 4));
			rreg(8'h47, 8'h20, "mirror");
			rreg(8'h47, 8'h20, "mirror_kept");
		end
		sts = 4'h0;
		// let the mirrored bit fall before checking is turned back on, or it would stay latched
		repeat (4) idle;
		m = $urandom;
		v = $urandom;
		acc(1, 8'h4C, {4'h0, m});
		acc(1, 8'h46, v);
		for (p = 0; p < 4; p++)
		begin
			acc(1, 8'h4C, 8'(p << 4));
			rreg(8'h46, m[p] ? v : 8'h00, "we");
		end
		$display("select test done");
		acc(1, 8'h4C, 8'h0F);
		acc(1, 8'h46, 8'h20);
		idle;
		fork
			fs.pulse(0, 0, 1'b0);
			begin
				repeat (2) @(negedge clk);
				rreg(8'h47, 8'h00, "pre_clear");
				idle;
			end
		join
		rreg(8'h47, 8'h01, "kept");
		acc(1, 8'h4A, 8'hFF);
		rreg(8'h4A, 8'h10, "cap_wr");
		chk("crc_en", 8'h0F, {4'h0, cap_en});
		crc_dis = 1;
		repeat (2) idle;
		chk("crc_off", 8'h00, {4'h0, cap_en});
		$display("capability test done");
		final_report;
	end
endmodule
